/* File: design/timer_clk_pkg.sv */
/*
  Shared constants and types for one timer channel's clock and clear
  control block. Assumes a single 40 MHz system clock and a 32-bit
  Avalon-MM register port with byte addresses.
*/
package timer_clk_pkg;

  // --------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // --------------------------------------------------------------
  localparam logic [3:0] CONTROL_OFFSET = 4'h0; // channel_control_reg
  localparam logic [3:0] CONFIG_OFFSET  = 4'h4; // sync, buffer, run bits
  localparam logic [3:0] COUNT_OFFSET   = 4'h8; // channel_count_value, RO

  // --------------------------------------------------------------
  // control register fields and reset values
  // --------------------------------------------------------------
  localparam int         SRC_SEL_LSB     = 0;
  localparam int         EDGE_SEL_LSB    = 3;
  localparam int         CLR_SEL_LSB     = 5;
  localparam int         RESERVED_BIT    = 7;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;

  // config register fields
  localparam int         CFG_SYNC_BIT    = 0;
  localparam int         CFG_BUF_C_BIT   = 1;
  localparam int         CFG_BUF_D_BIT   = 2;
  localparam int         CFG_RUN_BIT     = 3;
  localparam logic [3:0] CONFIG_RESET    = 4'h0;

  // --------------------------------------------------------------
  // prescaler taps: bit of the free counter giving phi/4, /16, /64
  // --------------------------------------------------------------
  localparam int         TAP_DIV4        = 1;
  localparam int         TAP_DIV16       = 3;
  localparam int         TAP_DIV64       = 5;
  localparam int         PRESCALE_WIDTH  = 6;

  // clock source encodings of the prescale-select field
  typedef enum logic [2:0] {
    SRC_DIV1  = 3'b000,
    SRC_DIV4  = 3'b001,
    SRC_DIV16 = 3'b010,
    SRC_DIV64 = 3'b011,
    SRC_PIN_A = 3'b100,
    SRC_PIN_B = 3'b101,
    SRC_PIN_C = 3'b110,
    SRC_PIN_D = 3'b111
  } clock_src_type;

  // clear source encodings of the clear-select field
  typedef enum logic [2:0] {
    CLR_NONE   = 3'b000,
    CLR_REG_A  = 3'b001,
    CLR_REG_B  = 3'b010,
    CLR_SYNC   = 3'b011,
    CLR_NONE_H = 3'b100,
    CLR_REG_C  = 3'b101,
    CLR_REG_D  = 3'b110,
    CLR_SYNC_H = 3'b111
  } clear_src_type;

  // control register layout
  typedef struct packed {
    logic [2:0] clear_source_sel;
    logic [1:0] edge_select;  // {edge_select_hi, edge_select_lo}
    logic [2:0] clock_source_sel;
  } control_type;

  // compare-match or capture strobes from the general registers
  typedef struct packed {
    logic general_reg_d;
    logic general_reg_c;
    logic general_reg_b;
    logic general_reg_a;
  } match_type;

endpackage

/* File: design/pin_edge_detect.sv */
/*
  Synchroniser and edge detector for the external clock pins.
  Assumes pin levels are asynchronous; two flops settle them before
  any edge is looked for.
*/
`timescale 1ns/1ps

module pin_edge_detect #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_n_i, // sync reset, active low
  input  wire logic [WIDTH-1:0] pin_i,   // raw pin levels
  output logic      [WIDTH-1:0] level_o, // synchronised level
  output logic      [WIDTH-1:0] prev_o   // level one cycle earlier
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_next;

  // --------------------------------------------------------------
  // synchroniser chain; only sync_reg reads meta_reg
  // --------------------------------------------------------------
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level_o = sync_reg;
  assign prev_o  = prev_reg;

endmodule

/* File: design/timer_clock_and_clear_select.sv */
/*
  Counter clock-source, edge and clear-source selection for one timer
  channel, with its counter and an Avalon-MM register slave.
  Assumes compare/capture strobes and sibling sync-clear pulses arrive
  synchronous to clk_i; external clock pins may be asynchronous.
*/
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

module timer_clock_and_clear_select #(
  parameter bit HAS_CD      = 1'b1, // channel with registers C and D
  parameter int COUNT_WIDTH = 16    // counter width
) (
  input  wire logic                   clk_i,          // 40 MHz clock
  input  wire logic                   rst_n_i,        // sync reset
  input  wire logic [3:0]             address_i,      // byte address
  input  wire logic                   read_i,         // read request
  input  wire logic                   write_i,        // write request
  input  wire logic [31:0]            writedata_i,    // write data
  input  wire logic [3:0]             byteenable_i,   // byte lanes
  output logic      [31:0]            readdata_o,     // read data
  output logic                        waitrequest_o,  // stall
  input  wire logic [3:0]             ext_clock_pin_i,// pins A..D
  input  wire timer_clk_pkg::match_type match_i,      // match strobes
  input  wire logic                   sync_clear_i,   // sibling clear
  output logic [COUNT_WIDTH-1:0]      count_value_o,  // counter
  output logic                        count_enable_o, // count pulse
  output logic                        counter_clear_o // sync clear out
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  timer_clk_pkg::control_type control_reg;
  timer_clk_pkg::control_type control_next;
  logic [3:0]                 config_reg;
  logic [3:0]                 config_next;
  logic                       ack_reg;
  logic                       ack_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic [timer_clk_pkg::PRESCALE_WIDTH-1:0] prescale_reg;
  logic [timer_clk_pkg::PRESCALE_WIDTH-1:0] prescale_next;
  logic [2:0]                 tap_prev_reg;
  logic [2:0]                 tap_prev_next;
  logic [COUNT_WIDTH-1:0]     count_reg;
  logic [COUNT_WIDTH-1:0]     count_next;
  logic                       enable_reg;
  logic                       enable_next;
  logic                       clear_out_reg;
  logic                       clear_out_next;

  logic [3:0]                 pin_level;
  logic [3:0]                 pin_prev;
  logic [2:0]                 tap_now;
  logic                       tick;
  logic                       clear_hit;
  logic                       run;
  logic                       sync_on;
  logic [7:0]                 control_rd;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // true when the chosen edge of a level shows between two samples
  function automatic logic edge_hit(input logic now,
                                    input logic prev,
                                    input logic [1:0] edge_sel);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    if (edge_sel[1]) begin
      edge_hit = rise | fall;
    end else if (edge_sel[0]) begin
      edge_hit = fall;
    end else begin
      edge_hit = rise;
    end
  endfunction

  // keeps only the bits that exist on this kind of channel
  function automatic logic [7:0] mask_control(input logic [7:0] v);
    logic [7:0] m;
    m = v;
    if (!HAS_CD) begin
      m[timer_clk_pkg::RESERVED_BIT] = 1'b0;
    end
    mask_control = m;
  endfunction

  // --------------------------------------------------------------
  // external pins: synchronised before any edge is looked for
  // --------------------------------------------------------------
  pin_edge_detect #(
    .WIDTH (4)
  ) u_pins (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (ext_clock_pin_i),
    .level_o (pin_level),
    .prev_o  (pin_prev)
  );

  assign run     = config_reg[timer_clk_pkg::CFG_RUN_BIT];
  assign sync_on = config_reg[timer_clk_pkg::CFG_SYNC_BIT];
  assign tap_now = {prescale_reg[timer_clk_pkg::TAP_DIV64],
                    prescale_reg[timer_clk_pkg::TAP_DIV16],
                    prescale_reg[timer_clk_pkg::TAP_DIV4]};
  assign control_rd = mask_control(control_reg);

  // --------------------------------------------------------------
  // clock source and edge selection
  // --------------------------------------------------------------
  // phi/1 counts every cycle; edges would be meaningless there
  always_comb begin
    tick = 1'b0;
    unique case (timer_clk_pkg::clock_src_type'(
                 control_reg.clock_source_sel))
      timer_clk_pkg::SRC_DIV1:  tick = 1'b1;
      timer_clk_pkg::SRC_DIV4:  tick = edge_hit(tap_now[0],
                         tap_prev_reg[0], control_reg.edge_select);
      timer_clk_pkg::SRC_DIV16: tick = edge_hit(tap_now[1],
                         tap_prev_reg[1], control_reg.edge_select);
      timer_clk_pkg::SRC_DIV64: tick = edge_hit(tap_now[2],
                         tap_prev_reg[2], control_reg.edge_select);
      timer_clk_pkg::SRC_PIN_A: tick = edge_hit(pin_level[0],
                         pin_prev[0], control_reg.edge_select);
      timer_clk_pkg::SRC_PIN_B: tick = edge_hit(pin_level[1],
                         pin_prev[1], control_reg.edge_select);
      timer_clk_pkg::SRC_PIN_C: tick = edge_hit(pin_level[2],
                         pin_prev[2], control_reg.edge_select);
      timer_clk_pkg::SRC_PIN_D: tick = edge_hit(pin_level[3],
                         pin_prev[3], control_reg.edge_select);
    endcase
  end

  // --------------------------------------------------------------
  // clear source selection
  // --------------------------------------------------------------
  // a buffered C or D has its match strobe masked off, so it can never clear
  always_comb begin
    clear_hit = 1'b0;
    unique case (timer_clk_pkg::clear_src_type'(
                 control_rd[timer_clk_pkg::CLR_SEL_LSB +: 3]))
      timer_clk_pkg::CLR_NONE:   clear_hit = 1'b0;
      timer_clk_pkg::CLR_REG_A:  clear_hit = match_i.general_reg_a;
      timer_clk_pkg::CLR_REG_B:  clear_hit = match_i.general_reg_b;
      timer_clk_pkg::CLR_SYNC:   clear_hit = sync_clear_i & sync_on;
      timer_clk_pkg::CLR_NONE_H: clear_hit = 1'b0;
      timer_clk_pkg::CLR_REG_C:  clear_hit = match_i.general_reg_c
                       & ~config_reg[timer_clk_pkg::CFG_BUF_C_BIT];
      timer_clk_pkg::CLR_REG_D:  clear_hit = match_i.general_reg_d
                       & ~config_reg[timer_clk_pkg::CFG_BUF_D_BIT];
      timer_clk_pkg::CLR_SYNC_H: clear_hit = sync_clear_i & sync_on;
    endcase
  end

  // --------------------------------------------------------------
  // prescaler and counter
  // --------------------------------------------------------------
  // prescaler free-runs so all channels share one phase of taps
  always_comb begin
    prescale_next  = prescale_reg + 1'b1;
    tap_prev_next  = tap_now;
    enable_next    = run & tick;
    clear_out_next = run & clear_hit & sync_on;
    count_next     = count_reg;
    if (run && clear_hit) begin
      count_next = '0;
    end else if (run && tick) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescale_reg  <= '0;
      tap_prev_reg  <= '0;
      count_reg     <= '0;
      enable_reg    <= 1'b0;
      clear_out_reg <= 1'b0;
    end else begin
      prescale_reg  <= prescale_next;
      tap_prev_reg  <= tap_prev_next;
      count_reg     <= count_next;
      enable_reg    <= enable_next;
      clear_out_reg <= clear_out_next;
    end
  end

  // --------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the access completes
  // --------------------------------------------------------------
  // control writes while running are accepted but not safe for
  // software; the counter may take a stray tick on the switch
  always_comb begin
    ack_next     = (read_i | write_i) & ~ack_reg;
    rdata_next   = rdata_reg;
    control_next = control_reg;
    config_next  = config_reg;
    if (read_i && !ack_reg) begin
      unique case (address_i)
        timer_clk_pkg::CONTROL_OFFSET: rdata_next = {24'h000000,
                                                     control_rd};
        timer_clk_pkg::CONFIG_OFFSET:  rdata_next = {28'h0000000,
                                                     config_reg};
        timer_clk_pkg::COUNT_OFFSET:   rdata_next = 32'(count_reg);
        default:                       rdata_next = 32'h00000000;
      endcase
    end
    if (write_i && ack_reg && byteenable_i[0]) begin
      if (address_i == timer_clk_pkg::CONTROL_OFFSET) begin
        control_next = mask_control(writedata_i[7:0]);
      end else if (address_i == timer_clk_pkg::CONFIG_OFFSET) begin
        config_next = writedata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h00000000;
      control_reg <= timer_clk_pkg::CONTROL_RESET;
      config_reg  <= timer_clk_pkg::CONFIG_RESET;
    end else begin
      ack_reg     <= ack_next;
      rdata_reg   <= rdata_next;
      control_reg <= control_next;
      config_reg  <= config_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign waitrequest_o   = (read_i | write_i) & ~ack_reg;
  assign readdata_o      = rdata_reg;
  assign count_value_o   = count_reg;
  assign count_enable_o  = enable_reg;
  assign counter_clear_o = clear_out_reg;

endmodule

/* File: testbench/pin_model.sv */
/*
  Far-side model: external clock pins that toggle the masked pins
  every half_i cycles. Assumes clk_i is the system clock.
*/
`timescale 1ns/1ps

module pin_model (
  input  wire logic       clk_i,  // system clock
  input  wire logic [3:0] mask_i, // pins that run
  input  wire logic [7:0] half_i, // half period in cycles
  output logic      [3:0] pin_o   // pin levels
);
  logic [7:0] cnt_reg = 8'h00;

  // ----------------------------------------------------------------
  // pin toggling
  // ----------------------------------------------------------------
  initial pin_o = 4'h0;
  // unmasked pins stand still, as an idle clock source would
  always @(posedge clk_i) begin
    cnt_reg <= (cnt_reg + 8'h01 >= half_i) ? 8'h00 : cnt_reg + 8'h01;
    if (cnt_reg == 8'h00) pin_o <= pin_o ^ mask_i;
  end
endmodule

/* File: testbench/timer_clk_monitor.sv */
/*
  Checker for the clock and clear select block, bound to its ports.
  Assumes single clock and that control only changes while stopped.
*/
`timescale 1ns/1ps

module timer_clk_monitor #(
  parameter bit HAS_CD      = 1'b1, // wide channel
  parameter int COUNT_WIDTH = 16    // counter width
) (
  input wire logic                   clk_i,           // clock
  input wire logic                   rst_n_i,         // reset
  input wire logic [3:0]             address_i,       // address
  input wire logic                   read_i,          // read
  input wire logic                   write_i,         // write
  input wire logic [31:0]            writedata_i,     // write data
  input wire logic [3:0]             byteenable_i,    // lanes
  input wire logic [31:0]            readdata_o,      // read data
  input wire logic                   waitrequest_o,   // stall
  input wire logic [3:0]             ext_clock_pin_i, // pins
  input wire timer_clk_pkg::match_type match_i,       // strobes
  input wire logic                   sync_clear_i,    // sibling clear
  input wire logic [COUNT_WIDTH-1:0] count_value_o,   // counter
  input wire logic                   count_enable_o,  // count pulse
  input wire logic                   counter_clear_o  // clear pulse
);
  logic [7:0] ctl_reg, ctl_next;
  logic [3:0] cfg_reg, cfg_next;
  logic       acc, run;

  // ----------------------------------------------------------------
  // shadow copies of control and config, taken on accepted writes
  // ----------------------------------------------------------------
  assign acc = write_i && !waitrequest_o && byteenable_i[0];
  assign run = cfg_reg[3];
  always_comb begin
    ctl_next = ctl_reg;
    cfg_next = cfg_reg;
    if (acc && address_i == timer_clk_pkg::CONTROL_OFFSET)
      ctl_next = {HAS_CD & writedata_i[7], writedata_i[6:0]};
    if (acc && address_i == timer_clk_pkg::CONFIG_OFFSET)
      cfg_next = writedata_i[3:0];
  end
  always_ff @(posedge clk_i) begin
    ctl_reg <= rst_n_i ? ctl_next : 8'h00;
    cfg_reg <= rst_n_i ? cfg_next : 4'h0;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wait_one;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access stalled more than one cycle");
  property p_div1;
    (run && ctl_reg[2:0] == 3'h0 && match_i == 4'h0 && !sync_clear_i)[*3]
      |-> count_enable_o;
  endproperty
  a_div1: assert property (p_div1)
    else $error("undivided clock missed a count");
  property p_div4_rise;
    run && ctl_reg[4:0] == 5'h01 && count_enable_o
      |=> !count_enable_o [*3];
  endproperty
  a_div4_rise: assert property (p_div4_rise)
    else $error("quarter clock counted too often");
  property p_div4_both;
    run && ctl_reg[4:0] == 5'h11 && count_enable_o
      |=> !count_enable_o ##1 (count_enable_o || !run);
  endproperty
  a_div4_both: assert property (p_div4_both)
    else $error("both-edge quarter clock off pace");
  property p_clear_a;
    run && ctl_reg[7:5] == 3'h1 && match_i.general_reg_a
      |=> count_value_o == '0;
  endproperty
  a_clear_a: assert property (p_clear_a)
    else $error("register A match did not clear");
  property p_clear_c;
    run && ctl_reg[7:5] == 3'h5 && !cfg_reg[1] && match_i.general_reg_c
      |=> count_value_o == '0;
  endproperty
  a_clear_c: assert property (p_clear_c)
    else $error("register C match did not clear");
  property p_buf_d;
    run && ctl_reg[7:5] == 3'h6 && cfg_reg[2] && match_i.general_reg_d
      |=> count_value_o != '0;
  endproperty
  a_buf_d: assert property (p_buf_d)
    else $error("buffered register D cleared the counter");
  property p_sync_off;
    run && ctl_reg[6:5] == 2'h3 && !cfg_reg[0] && sync_clear_i
      && ctl_reg[2:0] == 3'h0 |=> count_value_o != '0;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync clear acted without sync bit");
  property p_sync_pulse;
    run && ctl_reg[6:5] == 2'h3 && cfg_reg[0] && sync_clear_i
      |-> ##[1:2] counter_clear_o;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync clear gave no clear pulse");
  property p_narrow_rsv;
    !HAS_CD && read_i && !waitrequest_o
      && address_i == timer_clk_pkg::CONTROL_OFFSET |-> !readdata_o[7];
  endproperty
  a_narrow_rsv: assert property (p_narrow_rsv)
    else $error("reserved control bit read as one");
  c_pin_d: cover property (run && ctl_reg[2:0] == 3'h7 && count_enable_o);
  c_clear_c: cover property (ctl_reg[7:5] == 3'h5 && match_i.general_reg_c);
  c_sync: cover property (counter_clear_o);
endmodule

/* File: testbench/tb.sv */
/*
  Self-checking bench: wide and narrow channels share one bus and
  stimulus. Assumes the pin model as far side of the clock pins.
*/
`timescale 1ns/1ps

module tb;
  localparam logic [3:0] CTL = timer_clk_pkg::CONTROL_OFFSET;
  localparam logic [3:0] CFG = timer_clk_pkg::CONFIG_OFFSET;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, read_i = 1'b0;
  logic        write_i = 1'b0, sync_clear_i = 1'b0;
  logic [3:0]  address_i = 4'h0, byteenable_i = 4'h0, mask = 4'h0;
  logic [31:0] writedata_i = 32'h0, rd_w, rd_n, seed = 32'h2D, v;
  logic        wait_w, wait_n, en_w, clr_w;
  logic [3:0]  pins;
  logic [15:0] cnt_w;
  logic [63:0] expq[$];
  timer_clk_pkg::match_type match_i = '0;
  int          bad_count = 0, checks_done = 0;

  always #12.5 clk_i = ~clk_i;

  pin_model pin_model_i (.clk_i(clk_i), .mask_i(mask), .half_i(8'h08),
    .pin_o(pins));
  timer_clock_and_clear_select timer_clock_and_clear_select_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(rd_w),
    .waitrequest_o(wait_w), .ext_clock_pin_i(pins), .match_i(match_i),
    .sync_clear_i(sync_clear_i), .count_value_o(cnt_w),
    .count_enable_o(en_w), .counter_clear_o(clr_w));
  // narrow channel: same traffic, only its register view is compared
  timer_clock_and_clear_select #(.HAS_CD(1'b0)) narrow_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(rd_n),
    .waitrequest_o(wait_n), .ext_clock_pin_i(pins), .match_i(match_i),
    .sync_clear_i(sync_clear_i), .count_value_o(),
    .count_enable_o(), .counter_clear_o());

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master: hold until waitrequest low, then one idle edge
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    @(posedge clk_i);
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (wait_w !== 1'b0) begin
      @(posedge clk_i);
    end
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ew, en);
    expq.push_back({en, ew});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // counter must be stopped while control changes
  task automatic setup(input logic [7:0] ctl, input logic [3:0] cfg);
    bus(1'b1, CFG, 32'h0, 4'h1);
    bus(1'b1, CTL, {24'h0, ctl}, 4'h1);
    bus(1'b1, CFG, {28'h0, cfg}, 4'h1);
  endtask

  // whole periods in the window, so the tally is exact at any phase
  task automatic pulses(input int exp);
    logic [31:0] c;
    c = 32'h0;
    repeat (8) @(posedge clk_i);
    repeat (128) begin
      @(posedge clk_i);
      c = c + en_w;
    end
    check(c, exp);
  endtask

  // read results are compared in order as they appear
  // upper half of a note is the narrow channel's expected word
  always @(posedge clk_i) begin : rd_check
    logic [63:0] exp_word;
    if (read_i && wait_w === 1'b0) begin
      exp_word = expq.pop_front();
      check(rd_w, exp_word[31:0]);
      check(rd_n, exp_word[63:32]);
      check({31'h0, wait_n}, 32'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin : main
    int d;
    int k;
    logic ex;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(CTL, 32'h0, 32'h0);
    rd(CFG, 32'h0, 32'h0);
    rd(4'hC, 32'h0, 32'h0);
    rd(timer_clk_pkg::COUNT_OFFSET, 32'h0, 32'h0);
    // random control values; a write with no lane enabled is ignored
    repeat (8) begin
      v = rnd();
      bus(1'b1, CTL, v, 4'h1);
      bus(1'b1, CTL, ~v, 4'h0);
      rd(CTL, {24'h0, v[7:0]}, {25'h0, v[6:0]});
    end
    // every source and edge code, pins running one at a time
    for (int s = 0; s < 8; s++)
      for (int e = 0; e < 4; e++) begin
        mask <= (s > 3) ? 4'h1 << (s - 4) : 4'h0;
        setup({3'h0, e[1:0], s[2:0]}, 4'h8);
        d = (s > 3) ? 16 : 1 << (2 * s);
        pulses((s == 0 || e < 2) ? 128 / d : 256 / d);
      end
    mask <= 4'h0;
    // every clear code and sync/buffer setting, run always set; strobe aimed at the code or random
    for (int i = 0; i < 128; i++) begin
      v = rnd();
      setup({i[2:0], 5'h00}, {1'b1, i[5:3]});
      repeat (3) @(posedge clk_i);
      if (i[6] && i[1:0] == 2'h3) k = 4;
      else if (i[6] && i[1:0] != 2'h0) k = 2 * i[2] + i[1:0] - 1;
      else k = v[10:8] % 5;
      ex = (i[1:0] == 2'h1 && k == (i[2] ? 2 : 0) && !(i[2] && i[4]))
        || (i[1:0] == 2'h2 && k == (i[2] ? 3 : 1) && !(i[2] && i[5]))
        || (i[1:0] == 2'h3 && k == 4 && i[3]);
      if (k < 4) match_i <= 4'h1 << k;
      else sync_clear_i <= 1'b1;
      @(posedge clk_i);
      match_i <= '0;
      sync_clear_i <= 1'b0;
      @(posedge clk_i);
      check({31'h0, cnt_w == 16'h0}, {31'h0, ex});
      check({31'h0, clr_w}, {31'h0, ex && i[3]});
    end
    give_verdict();
  end
endmodule

bind timer_clock_and_clear_select timer_clk_monitor #(
  .HAS_CD(HAS_CD), .COUNT_WIDTH(COUNT_WIDTH)) timer_clk_monitor_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .ext_clock_pin_i(ext_clock_pin_i),
  .match_i(match_i), .sync_clear_i(sync_clear_i),
  .count_value_o(count_value_o), .count_enable_o(count_enable_o),
  .counter_clear_o(counter_clear_o));
